// ===== src/dpg_pkg.sv
// package of register map, reset values and pin-function encodings for the dual port gpio block
package dpg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_THIRD_PINS = 4'h0;
  localparam logic [3:0] OFF_THIRD_DIR = 4'h1;
  localparam logic [3:0] OFF_FOURTH_PINS = 4'h2;
  localparam logic [3:0] OFF_FOURTH_DIR = 4'h3;
  localparam logic [3:0] OFF_LCD_CTRL = 4'h4;
  localparam logic [3:0] OFF_FUNC_SEL = 4'h5;
  localparam logic [3:0] OFF_RESET_CAUSE = 4'h6;
  // reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_POR = 8'h00;
  localparam logic [7:0] LCD_CTRL_RESET = 8'h00;
  localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
  // lcd control fields
  localparam int LCD_BIAS_EN_BIT = 0;
  localparam int LCD_SEG3_BIT = 1;
  localparam int LCD_SEG4_BIT = 2;
  localparam int LCD_SEG5_BIT = 3;
  localparam int LCD_LCD_SEGMENT_OUT_6_BIT = 4;
  localparam int LCD_SEG7_BIT = 5;
  // function select fields
  localparam int FS_GATE_BIT = 0;
  localparam int FS_TCLK_BIT = 1;
  localparam int FS_CCP_BIT = 2;
  // reset-cause bits
  localparam int RC_POR_BIT = 0;
endpackage

// ===== src/dpg_sync.sv
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/10ps
`default_nettype none
module dpg_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_n, // synchronised reset, active low
  input wire logic [WIDTH-1:0] i_async, // raw pins
  output logic [WIDTH-1:0] o_sync // synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dpg_sync_s;
  dpg_sync_s st;
  dpg_sync_s next_st;
  always_comb begin
    next_st.stage1 = i_async;
    next_st.stage2 = st.stage1;
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_sync = st.stage2;
endmodule
`default_nettype wire

// ===== src/dpg_pin_mux.sv
// per-pin output source selection for the third port
`timescale 1ns/10ps
`default_nettype none
module dpg_pin_mux (
  input wire logic [7:0] i_latch, // port latch
  input wire logic [7:0] i_dir, // direction, 1 = input
  input wire logic i_uart_en, // async serial engine owns pins 6/7
  input wire logic i_uart_tx, // async transmit data
  input wire logic i_uart_oe, // async engine drives pin 7 (sync data)
  input wire logic i_uart_d7, // async engine data for pin 7
  input wire logic i_ssp_en, // sync serial port enabled
  input wire logic i_ssp_sdo, // sync serial data out, pin 4
  input wire logic i_ssp_sck_oe, // sync port drives clock on pin 6
  input wire logic i_ssp_sck, // sync port clock
  input wire logic i_ssp_sda_oe, // sync port drives pin 7
  input wire logic i_ssp_sda, // sync port pin 7 data
  input wire logic i_ccp_en, // compare/pwm owns pin 5
  input wire logic i_ccp_out, // compare/pwm value
  input wire logic [7:0] i_analog, // pins held by lcd analog function
  output logic [7:0] o_out, // resolved data
  output logic [7:0] o_drive // 1 = pin driven
);
  always_comb begin
    o_out = i_latch;
    o_drive = ~i_dir;
    if (i_ssp_en) begin
      o_out[4] = i_ssp_sdo;
    end
    if (i_ccp_en) begin
      o_out[5] = i_ccp_out;
    end
    // serial engine before sync port before latch
    if (i_uart_en) begin
      o_out[6] = i_uart_tx;
      if (i_uart_oe) begin
        o_out[7] = i_uart_d7;
      end
    end else if (i_ssp_en) begin
      if (i_ssp_sck_oe) begin
        o_out[6] = i_ssp_sck;
      end
      if (i_ssp_sda_oe) begin
        o_out[7] = i_ssp_sda;
      end
    end
    // analog use releases the digital driver
    o_drive = o_drive & ~i_analog;
  end
endmodule
`default_nettype wire

// ===== src/dpg_top.sv
// dual 8-bit gpio ports with register port and third-port peripheral sharing
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - third port has eight two-way pins, schmitt inputs, shared with peripherals
// - writing third-port pins updates latch, driven on output pins
// - third-port direction bit 1 means input, 0 means drive
// - reading third-port pins returns sampled pin levels
// - any reset sets third-port direction to all ones
// - third-port latch cleared only at power-on; other resets keep it
// - output priority: serial engine, then sync port, then latch
// - pins 0..2 may be lcd bias analog inputs
// - pin 5: gpio, timer clock, capture/compare/pwm, segment
// - pin 6: gpio, async transmit, sync clock, spi clock, i2c, segment
// - pin 7: gpio, async receive, sync data, spi in, i2c data, segment
// - fourth port has eight schmitt pins, each direction set alone
// - fourth port may be removed by build option
// - fourth-port direction 1 input, 0 drives latch
// - fourth-port reads give pin levels, writes update latch
// - any reset sets fourth direction to ones, latch kept on warm reset
module dpg_top #(
  parameter bit HAS_FOURTH_PORT = 1'b1
) (
  input wire logic i_core_clk, // core clock, 25 MHz
  input wire logic i_nrst, // async reset, active low
  input wire logic i_por, // power-on or brown-out reset in progress, high
  input wire logic [3:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  input wire logic [7:0] i_third_pin, // third port pin levels
  output logic [7:0] o_third_pin, // third port pin data
  output logic [7:0] o_third_pin_oe_n, // third port enable, low drives
  input wire logic [7:0] i_fourth_pin, // fourth port pin levels
  output logic [7:0] o_fourth_pin, // fourth port pin data
  output logic [7:0] o_fourth_pin_oe_n, // fourth port enable, low drives
  input wire logic i_uart_en, // async serial engine enabled
  input wire logic i_uart_tx, // async transmit
  input wire logic i_uart_oe, // async engine drives pin 7
  input wire logic i_uart_d7, // async pin 7 data
  input wire logic i_ssp_en, // sync serial port enabled
  input wire logic i_ssp_sdo, // sync serial data out
  input wire logic i_ssp_sck_oe, // sync clock driven
  input wire logic i_ssp_sck, // sync clock value
  input wire logic i_ssp_sda_oe, // sync pin 7 driven
  input wire logic i_ssp_sda, // sync pin 7 value
  input wire logic i_ccp_out, // compare/pwm output value
  input wire logic [7:0] i_lcd_seg, // lcd segment values, not used by the logic
  output logic o_timer_gate_in, // pin 4 to timer gate
  output logic o_timer_ext_clock_in, // pin 5 to timer clock
  output logic o_capture_in, // pin 5 to capture
  output logic o_sync_serial_data_in, // pin 7 to sync port / async rx
  output logic o_sync_serial_clock_in, // pin 6 to sync port
  output logic o_lcd_bias_en // lcd bias levels 1..3 on pins 0..2
);
  typedef struct packed {
    logic por_seen;
    logic [7:0] third_dir;
    logic [7:0] fourth_dir;
    logic [7:0] lcd_ctrl;
    logic [7:0] func_sel;
    logic [7:0] rdata;
    logic [7:0] third_out;
    logic [7:0] third_oe_n;
    logic [7:0] fourth_out;
    logic [7:0] fourth_oe_n;
    logic tgate;
    logic tclk;
    logic cap;
    logic sync_serial_data_in;
    logic sck_in;
    logic bias_en;
  } dpg_top_s;

  // latches held apart: they have no reset, so warm resets keep them
  typedef struct packed {
    logic [7:0] third_latch;
    logic [7:0] fourth_latch;
  } dpg_kept_s;

  dpg_top_s st;
  dpg_top_s next_st;
  dpg_kept_s kept;
  dpg_kept_s next_kept;
  logic [1:0] rst_sync;
  logic rst_n;
  logic por_s;
  logic [7:0] third_s;
  logic [7:0] fourth_s;
  logic [7:0] mux_out;
  logic [7:0] mux_drive;
  logic [7:0] analog;
  logic [7:0] seg_en;

  assign rst_n = rst_sync[1];

  dpg_sync #(.WIDTH(8)) u_sync_third (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_async(i_third_pin),
    .o_sync(third_s)
  );

  dpg_sync #(.WIDTH(9)) u_sync_fourth (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_async({i_por, i_fourth_pin}),
    .o_sync({por_s, fourth_s})
  );

  // lcd segment enables per pin; segments and bias are analog, driver released
  always_comb begin
    seg_en = 8'h00;
    seg_en[3] = st.lcd_ctrl[dpg_pkg::LCD_SEG3_BIT];
    seg_en[4] = st.lcd_ctrl[dpg_pkg::LCD_SEG4_BIT];
    seg_en[5] = st.lcd_ctrl[dpg_pkg::LCD_SEG5_BIT];
    seg_en[6] = st.lcd_ctrl[dpg_pkg::LCD_LCD_SEGMENT_OUT_6_BIT];
    seg_en[7] = st.lcd_ctrl[dpg_pkg::LCD_SEG7_BIT];
    analog = {5'h00, {3{st.lcd_ctrl[dpg_pkg::LCD_BIAS_EN_BIT]}}};
  end

  dpg_pin_mux u_mux (
    .i_latch(kept.third_latch),
    .i_dir(st.third_dir),
    .i_uart_en(i_uart_en),
    .i_uart_tx(i_uart_tx),
    .i_uart_oe(i_uart_oe),
    .i_uart_d7(i_uart_d7),
    .i_ssp_en(i_ssp_en),
    .i_ssp_sdo(i_ssp_sdo),
    .i_ssp_sck_oe(i_ssp_sck_oe),
    .i_ssp_sck(i_ssp_sck),
    .i_ssp_sda_oe(i_ssp_sda_oe),
    .i_ssp_sda(i_ssp_sda),
    .i_ccp_en(st.func_sel[dpg_pkg::FS_CCP_BIT]),
    .i_ccp_out(i_ccp_out),
    .i_analog(analog),
    .o_out(mux_out),
    .o_drive(mux_drive)
  );

  always_comb begin
    next_st = st;
    next_kept = kept;
    next_st.por_seen = 1'b0;
    // latch clear on power-on only; warm resets leave it
    if (por_s && !st.por_seen) begin
      next_kept.third_latch = dpg_pkg::LATCH_POR;
      next_kept.fourth_latch = dpg_pkg::LATCH_POR;
      next_st.por_seen = 1'b1;
    end else if (por_s) begin
      next_st.por_seen = 1'b1;
    end
    if (i_wr) begin
      case (i_addr)
        dpg_pkg::OFF_THIRD_PINS: next_kept.third_latch = i_wdata;
        dpg_pkg::OFF_THIRD_DIR: next_st.third_dir = i_wdata;
        dpg_pkg::OFF_FOURTH_PINS: begin
          if (HAS_FOURTH_PORT) begin
            next_kept.fourth_latch = i_wdata;
          end
        end
        dpg_pkg::OFF_FOURTH_DIR: begin
          if (HAS_FOURTH_PORT) begin
            next_st.fourth_dir = i_wdata;
          end
        end
        dpg_pkg::OFF_LCD_CTRL: next_st.lcd_ctrl = i_wdata;
        dpg_pkg::OFF_FUNC_SEL: next_st.func_sel = i_wdata;
        default: next_st.rdata = st.rdata;
      endcase
    end
    next_st.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        dpg_pkg::OFF_THIRD_PINS: next_st.rdata = third_s;
        dpg_pkg::OFF_THIRD_DIR: next_st.rdata = st.third_dir;
        dpg_pkg::OFF_FOURTH_PINS: next_st.rdata = HAS_FOURTH_PORT ? fourth_s : 8'h00;
        dpg_pkg::OFF_FOURTH_DIR: next_st.rdata = HAS_FOURTH_PORT ? st.fourth_dir : 8'h00;
        dpg_pkg::OFF_LCD_CTRL: next_st.rdata = st.lcd_ctrl;
        dpg_pkg::OFF_FUNC_SEL: next_st.rdata = st.func_sel;
        dpg_pkg::OFF_RESET_CAUSE: next_st.rdata = {7'h00, por_s};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // pins registered so they follow the registers one cycle later
    next_st.third_out = mux_out;
    next_st.third_oe_n = ~(mux_drive & ~seg_en);
    next_st.fourth_out = HAS_FOURTH_PORT ? kept.fourth_latch : 8'h00;
    next_st.fourth_oe_n = HAS_FOURTH_PORT ? st.fourth_dir : 8'hff;
    // inputs routed from synchronised pins
    next_st.tgate = third_s[4] & st.func_sel[dpg_pkg::FS_GATE_BIT];
    next_st.tclk = third_s[5] & st.func_sel[dpg_pkg::FS_TCLK_BIT];
    next_st.cap = third_s[5];
    next_st.sck_in = third_s[6];
    next_st.sync_serial_data_in = third_s[7];
    next_st.bias_en = st.lcd_ctrl[dpg_pkg::LCD_BIAS_EN_BIT];
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // latches sit outside reset so warm resets keep them
  always_ff @(posedge i_core_clk) begin
    kept <= next_kept;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.por_seen <= 1'b0;
      st.third_dir <= dpg_pkg::DIR_RESET;
      st.fourth_dir <= dpg_pkg::DIR_RESET;
      st.lcd_ctrl <= dpg_pkg::LCD_CTRL_RESET;
      st.func_sel <= dpg_pkg::FUNC_SEL_RESET;
      st.rdata <= 8'h00;
      st.third_out <= 8'h00;
      st.third_oe_n <= 8'hff;
      st.fourth_out <= 8'h00;
      st.fourth_oe_n <= 8'hff;
      st.tgate <= 1'b0;
      st.tclk <= 1'b0;
      st.cap <= 1'b0;
      st.sync_serial_data_in <= 1'b0;
      st.sck_in <= 1'b0;
      st.bias_en <= 1'b0;
    end else begin
      st.por_seen <= next_st.por_seen;
      st.third_dir <= next_st.third_dir;
      st.fourth_dir <= next_st.fourth_dir;
      st.lcd_ctrl <= next_st.lcd_ctrl;
      st.func_sel <= next_st.func_sel;
      st.rdata <= next_st.rdata;
      st.third_out <= next_st.third_out;
      st.third_oe_n <= next_st.third_oe_n;
      st.fourth_out <= next_st.fourth_out;
      st.fourth_oe_n <= next_st.fourth_oe_n;
      st.tgate <= next_st.tgate;
      st.tclk <= next_st.tclk;
      st.cap <= next_st.cap;
      st.sync_serial_data_in <= next_st.sync_serial_data_in;
      st.sck_in <= next_st.sck_in;
      st.bias_en <= next_st.bias_en;
    end
  end

  assign o_rdata = st.rdata;
  assign o_third_pin = st.third_out;
  assign o_third_pin_oe_n = st.third_oe_n;
  assign o_fourth_pin = st.fourth_out;
  assign o_fourth_pin_oe_n = st.fourth_oe_n;
  assign o_timer_gate_in = st.tgate;
  assign o_timer_ext_clock_in = st.tclk;
  assign o_capture_in = st.cap;
  assign o_sync_serial_data_in = st.sync_serial_data_in;
  assign o_sync_serial_clock_in = st.sck_in;
  assign o_lcd_bias_en = st.bias_en;
endmodule
`default_nettype wire

// ===== testbench/dpg_chk.sv
// assertion checker watching the dual port gpio top ports
`timescale 1ns/10ps
`default_nettype none
module dpg_chk #(
  parameter bit HAS_FOURTH_PORT = 1'b1
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_nrst, // reset, active low
  input wire logic [3:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [7:0] o_rdata, // read data
  input wire logic [7:0] o_third_pin, // third port data
  input wire logic [7:0] o_third_pin_oe_n, // third port enable, low drives
  input wire logic [7:0] o_fourth_pin, // fourth port data
  input wire logic [7:0] o_fourth_pin_oe_n, // fourth port enable, low drives
  input wire logic i_uart_en, // async engine on
  input wire logic i_uart_tx, // async transmit
  input wire logic i_ssp_en, // sync port on
  input wire logic i_ssp_sdo, // sync data out
  input wire logic o_lcd_bias_en // lcd bias on
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  logic w3l;
  logic w3d;
  logic w4l;
  logic w4d;
  assign w3l = i_wr && i_addr == dpg_pkg::OFF_THIRD_PINS;
  assign w3d = i_wr && i_addr == dpg_pkg::OFF_THIRD_DIR;
  assign w4l = i_wr && i_addr == dpg_pkg::OFF_FOURTH_PINS;
  assign w4d = i_wr && i_addr == dpg_pkg::OFF_FOURTH_DIR;
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_RESET_DIR: assert property ($rose(i_nrst) |-> o_third_pin_oe_n == 8'hff && o_fourth_pin_oe_n == 8'hff)
    else $error("pins not released at reset");
  AST_THIRD_ALL_IN: assert property (w3d && i_wdata == 8'hff ##1 !w3d |=> o_third_pin_oe_n == 8'hff)
    else $error("third port drives with direction all ones");
  AST_FOURTH_DIR: assert property (HAS_FOURTH_PORT && w4d ##1 !w4d |=> o_fourth_pin_oe_n == $past(i_wdata, 2))
    else $error("fourth port enable differs from direction");
  AST_FOURTH_LATCH: assert property (w4l ##1 !w4l |=> ((o_fourth_pin ^ $past(i_wdata, 2)) & ~o_fourth_pin_oe_n) == 8'h00)
    else $error("fourth port driven data differs from latch");
  AST_THIRD_LATCH: assert property (w3l ##1 !w3l |=> ((o_third_pin ^ $past(i_wdata, 2)) & ~o_third_pin_oe_n & 8'h0f) == 8'h00)
    else $error("third port driven data differs from latch");
  AST_UART_FIRST: assert property ((i_uart_en && $stable(i_uart_tx))[*3] ##0 !o_third_pin_oe_n[6] |-> o_third_pin[6] == i_uart_tx)
    else $error("pin 6 not taken by async transmit");
  AST_SDO_PIN4: assert property ((i_ssp_en && $stable(i_ssp_sdo))[*3] ##0 !o_third_pin_oe_n[4] |-> o_third_pin[4] == i_ssp_sdo)
    else $error("pin 4 not taken by sync data out");
  AST_BIAS_FREE: assert property (o_lcd_bias_en && $past(o_lcd_bias_en) |-> o_third_pin_oe_n[2:0] == 3'b111)
    else $error("bias pins driven while bias on");
  COV_BOTH_SERIAL: cover property (i_uart_en && i_ssp_en);
  COV_BIAS: cover property (o_lcd_bias_en);
  COV_FOURTH_OUT: cover property (o_fourth_pin_oe_n == 8'h00);
endmodule
bind dpg_top dpg_chk #(.HAS_FOURTH_PORT(HAS_FOURTH_PORT)) chk_u (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_third_pin(o_third_pin),
  .o_third_pin_oe_n(o_third_pin_oe_n), .o_fourth_pin(o_fourth_pin), .o_fourth_pin_oe_n(o_fourth_pin_oe_n),
  .i_uart_en(i_uart_en), .i_uart_tx(i_uart_tx), .i_ssp_en(i_ssp_en), .i_ssp_sdo(i_ssp_sdo),
  .o_lcd_bias_en(o_lcd_bias_en));
`default_nettype wire

// ===== testbench/dpg_board.sv
// board model: resolves each port pin from device drive and board drive
`timescale 1ns/10ps
`default_nettype none
module dpg_board (
  input wire logic [7:0] i_out3, // device data, third port
  input wire logic [7:0] i_oe3_n, // device enable, third port
  input wire logic [7:0] i_out4, // device data, fourth port
  input wire logic [7:0] i_oe4_n, // device enable, fourth port
  input wire logic [7:0] i_ext3, // board drive on released pins
  input wire logic [7:0] i_ext4, // board drive on released pins
  output logic [7:0] o_lvl3, // third port wire levels
  output logic [7:0] o_lvl4 // fourth port wire levels
);
  // board drives only released pins, so no contention is modelled
  assign o_lvl3 = (i_out3 & ~i_oe3_n) | (i_ext3 & i_oe3_n);
  assign o_lvl4 = (i_out4 & ~i_oe4_n) | (i_ext4 & i_oe4_n);
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the dual port gpio block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic por = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic uen = 1'b0, utx = 1'b0, uoe = 1'b0, ud7 = 1'b0, sen = 1'b0, sync_serial_data_out = 1'b0;
  logic sckoe = 1'b0, sck = 1'b0, sdaoe = 1'b0, sda = 1'b0, ccp = 1'b0;
  logic [7:0] ext3 = 8'h00, ext4 = 8'h00, lvl3, lvl4, rdata, p3, oe3, p4, oe4;
  logic tg, tck, cap, sync_serial_data_in, sckin, bias;
  logic [7:0] l3, d3, l4, d4, e3, e4;
  logic x6, x7, x4;
  integer seed = 32'haa6331bf;
  integer fails = 0;
  integer compares = 0;
  always #20 clk = ~clk;
  dpg_top dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_por(por), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_third_pin(lvl3), .o_third_pin(p3), .o_third_pin_oe_n(oe3),
    .i_fourth_pin(lvl4), .o_fourth_pin(p4), .o_fourth_pin_oe_n(oe4), .i_uart_en(uen), .i_uart_tx(utx),
    .i_uart_oe(uoe), .i_uart_d7(ud7), .i_ssp_en(sen), .i_ssp_sdo(sync_serial_data_out), .i_ssp_sck_oe(sckoe), .i_ssp_sck(sck),
    .i_ssp_sda_oe(sdaoe), .i_ssp_sda(sda), .i_ccp_out(ccp), .i_lcd_seg(8'h00), .o_timer_gate_in(tg),
    .o_timer_ext_clock_in(tck), .o_capture_in(cap), .o_sync_serial_data_in(sync_serial_data_in),
    .o_sync_serial_clock_in(sckin), .o_lcd_bias_en(bias));
  dpg_board board_u (.i_out3(p3), .i_oe3_n(oe3), .i_out4(p4), .i_oe4_n(oe4), .i_ext3(ext3), .i_ext4(ext4),
    .o_lvl3(lvl3), .o_lvl4(lvl4));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic idle(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  // por held across the release so the synchronised copy is seen rising
  task automatic do_reset(input logic p);
    @(posedge clk);
    nrst <= 1'b0;
    por <= p;
    idle(2);
    nrst <= 1'b1;
    idle(4);
    por <= 1'b0;
    idle(2);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
  initial begin
    do_reset(1'b1);
    chk("oe3", 8'hff, oe3);
    chk("oe4", 8'hff, oe4);
    // released pins still carry the latch, so the power-on clear shows here
    chk("p3 por", dpg_pkg::LATCH_POR, p3);
    chk("p4 por", dpg_pkg::LATCH_POR, p4);
    rchk("dir3", dpg_pkg::OFF_THIRD_DIR, 8'hff);
    rchk("dir4", dpg_pkg::OFF_FOURTH_DIR, 8'hff);
    rchk("unmapped", 4'hf, 8'h00);
    wreg(dpg_pkg::OFF_THIRD_PINS, 8'h00);
    wreg(dpg_pkg::OFF_FOURTH_PINS, 8'h00);
    wreg(dpg_pkg::OFF_THIRD_DIR, 8'h00);
    wreg(dpg_pkg::OFF_FOURTH_DIR, 8'h00);
    idle(2);
    chk("p3 clear", 8'h00, p3);
    chk("p4 clear", 8'h00, p4);
    for (int i = 0; i < 8; i++) begin
      {l3, d3, l4, d4} = $random(seed);
      {e3, e4} = 16'($random(seed));
      ext3 <= e3;
      ext4 <= e4;
      wreg(dpg_pkg::OFF_THIRD_PINS, l3);
      wreg(dpg_pkg::OFF_THIRD_DIR, d3);
      wreg(dpg_pkg::OFF_FOURTH_PINS, l4);
      wreg(dpg_pkg::OFF_FOURTH_DIR, d4);
      idle(1);
      chk("oe4", d4, oe4);
      chk("p4 out", l4 & ~d4, p4 & ~oe4);
      chk("oe3", d3, oe3);
      chk("p3 out", l3 & ~d3, p3 & ~oe3);
      idle(3);
      rchk("pins3", dpg_pkg::OFF_THIRD_PINS, (l3 & ~d3) | (e3 & d3));
      rchk("pins4", dpg_pkg::OFF_FOURTH_PINS, (l4 & ~d4) | (e4 & d4));
      rchk("dir4", dpg_pkg::OFF_FOURTH_DIR, d4);
    end
    do_reset(1'b0);
    chk("oe3 warm", 8'hff, oe3);
    chk("oe4 warm", 8'hff, oe4);
    wreg(dpg_pkg::OFF_THIRD_DIR, 8'h00);
    wreg(dpg_pkg::OFF_FOURTH_DIR, 8'h00);
    idle(2);
    chk("p3 warm", l3, p3);
    chk("p4 warm", l4, p4);
    for (int k = 0; k < 4; k++) begin
      {uen, sen} <= k[1:0];
      {utx, ud7, sck, sda, sync_serial_data_out} <= 5'($random(seed));
      {uoe, sckoe, sdaoe} <= 3'b111;
      idle(4);
      x6 = uen ? utx : sen ? sck : l3[6];
      x7 = uen ? ud7 : sen ? sda : l3[7];
      x4 = sen ? sync_serial_data_out : l3[4];
      chk("pin6", {7'h00, x6}, {7'h00, p3[6]});
      chk("pin7", {7'h00, x7}, {7'h00, p3[7]});
      chk("pin4", {7'h00, x4}, {7'h00, p3[4]});
      chk("rx in", {7'h00, x7}, {7'h00, sync_serial_data_in});
      chk("clk in", {7'h00, x6}, {7'h00, sckin});
    end
    {uen, sen} <= 2'b00;
    e3 = 8'($random(seed));
    ext3 <= e3;
    wreg(dpg_pkg::OFF_THIRD_DIR, 8'hff);
    wreg(dpg_pkg::OFF_FUNC_SEL, 8'h07);
    idle(4);
    chk("gate", {7'h00, e3[4]}, {7'h00, tg});
    chk("tclk", {7'h00, e3[5]}, {7'h00, tck});
    chk("capture", {7'h00, e3[5]}, {7'h00, cap});
    ccp <= ~e3[5];
    wreg(dpg_pkg::OFF_THIRD_DIR, 8'hdf);
    idle(3);
    chk("ccp pin", {7'h00, ~e3[5]}, {7'h00, p3[5]});
    wreg(dpg_pkg::OFF_THIRD_DIR, 8'h00);
    wreg(dpg_pkg::OFF_LCD_CTRL, 8'h01);
    idle(3);
    chk("bias", 8'h01, {7'h00, bias});
    chk("bias oe", 8'h07, oe3 & 8'h07);
    wreg(dpg_pkg::OFF_LCD_CTRL, 8'h3f);
    idle(3);
    chk("segments", 8'hff, oe3);
    wrap_up();
  end
endmodule
`default_nettype wire
